// File: design/css_card_detect.v
// card presence sensing from the two card-detect inputs
`timescale 1ns/1ns
module css_card_detect (
   input wire clk_in,
   input wire reset_in,
   input wire card_detect_one_n_in,
   input wire card_detect_two_n_in,
   output reg [1:0] detect_level_out,
   output reg card_present_out
);
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         detect_level_out <= 2'h3;
         card_present_out <= 1'b0;
      end else begin
         detect_level_out <= {card_detect_two_n_in, card_detect_one_n_in};
         // both pins must be low: a half-seated card is not present
         card_present_out <= ~card_detect_one_n_in & ~card_detect_two_n_in;
      end
   end
endmodule // css_card_detect

// File: design/css_defines.vh
// constants for the 16-bit card socket strobe and dma block
`ifndef CSS_DEFINES_VH
`define CSS_DEFINES_VH
// strobe timing in ns, derived into cycles of the 50 MHz clock
`define CSS_CLK_PERIOD_NS 20
`define CSS_SETUP_NS 60
`define CSS_STROBE_NS 160
`define CSS_HOLD_NS 40
`define CSS_SETUP_CYC ((`CSS_SETUP_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS)
`define CSS_STROBE_CYC ((`CSS_STROBE_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS)
`define CSS_HOLD_CYC ((`CSS_HOLD_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS)
`define CSS_CNT_W 4
// request kinds
`define CSS_OP_IO_READ 2'h0
`define CSS_OP_IO_WRITE 2'h1
`define CSS_OP_DMA_C2H 2'h2
`define CSS_OP_DMA_H2C 2'h3
// dma request source select
`define CSS_DREQ_BATT 1'b0
`define CSS_DREQ_INACK 1'b1
// reset value of every active-low pin
`define CSS_PIN_IDLE 1'b1
`endif

// File: design/css_socket.v
// socket strobe sequencer for host i/o cycles and card dma transfers
`timescale 1ns/1ns
`include "css_defines.vh"
module css_socket (
   input wire clk_in,
   input wire reset_in,
   // host side request
   input wire req_valid_in,
   input wire [1:0] req_op_in,
   input wire [25:0] req_addr_in,
   input wire [1:0] req_bytes_in,
   input wire [15:0] req_wdata_in,
   input wire req_last_in,
   input wire dma_enable_in,
   input wire dma_req_select_in,
   output reg req_ready_out,
   output reg done_out,
   output reg [15:0] rdata_out,
   output reg read_acked_out,
   output reg dma_request_out,
   output reg card_present_out,
   output reg [1:0] card_detect_level_out,
   // card pins
   input wire card_detect_one_n_in,
   input wire card_detect_two_n_in,
   input wire battery_detect_two_n_in,
   input wire input_acknowledge_n_in,
   input wire wait_n_in,
   input wire [15:0] card_data_in,
   output reg [15:0] card_data_out,
   output reg card_data_oe_out,
   output reg [25:0] card_addr_out,
   output reg even_byte_enable_n_out,
   output reg odd_byte_enable_n_out,
   output reg io_read_strobe_n_out,
   output reg io_write_strobe_n_out,
   output reg attr_select_n_out,
   output reg output_enable_n_out,
   output reg write_enable_n_out
);
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_SETUP = 4'b0010;
   localparam [3:0] ST_STROBE = 4'b0100;
   localparam [3:0] ST_HOLD = 4'b1000;
   // cycle counts arrive as 32-bit integers; cut to the counter width on purpose
   localparam integer SETUP_CYC = `CSS_SETUP_CYC;
   localparam integer STROBE_CYC = `CSS_STROBE_CYC;
   localparam integer HOLD_CYC = `CSS_HOLD_CYC;
   localparam [`CSS_CNT_W-1:0] SETUP_CNT = SETUP_CYC[`CSS_CNT_W-1:0];
   localparam [`CSS_CNT_W-1:0] STROBE_CNT = STROBE_CYC[`CSS_CNT_W-1:0];
   localparam [`CSS_CNT_W-1:0] HOLD_CNT = HOLD_CYC[`CSS_CNT_W-1:0];

   // byte enables: bit0 even, bit1 odd, mapped to active-low pins
   function [1:0] byte_enables_n;
      input [1:0] bytes;
      begin
         byte_enables_n = ~bytes;
      end
   endfunction

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [`CSS_CNT_W-1:0] count_reg;
   reg [`CSS_CNT_W-1:0] count_next;
   reg [1:0] op_reg;
   reg last_reg;
   reg wait_sync_reg;
   reg wait_held_reg;
   wire [1:0] detect_level;
   wire present;
   wire is_dma;
   wire is_read;
   wire dreq;
   wire [1:0] lanes_n;

   css_card_detect u_detect (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .card_detect_one_n_in(card_detect_one_n_in),
      .card_detect_two_n_in(card_detect_two_n_in),
      .detect_level_out(detect_level),
      .card_present_out(present)
   );

   assign is_dma = op_reg[1];
   assign is_read = (op_reg == `CSS_OP_IO_READ) || (op_reg == `CSS_OP_DMA_C2H);
   assign lanes_n = byte_enables_n(req_bytes_in);
   // either pin may carry the card's dma request
   assign dreq = (dma_req_select_in == `CSS_DREQ_INACK) ? ~input_acknowledge_n_in
                                                        : ~battery_detect_two_n_in;

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         ST_IDLE: begin
            // refuse when no card: strobes must stay idle
            if (req_valid_in && present && (!req_op_in[1] || dma_enable_in)) begin
               state_next = ST_SETUP;
               count_next = SETUP_CNT;
            end
         end
         ST_SETUP: begin
            if (count_reg <= 1) begin
               state_next = ST_STROBE;
               count_next = STROBE_CNT;
            end else begin
               count_next = count_reg - 1'b1;
            end
         end
         ST_STROBE: begin
            // wait is sampled registered, so strobe end waits one extra look
            if (count_reg > 1) begin
               count_next = count_reg - 1'b1;
            end else if (!wait_held_reg && !wait_sync_reg) begin
               state_next = ST_HOLD;
               count_next = HOLD_CNT;
            end
         end
         ST_HOLD: begin
            if (count_reg <= 1) begin
               state_next = ST_IDLE;
               count_next = {`CSS_CNT_W{1'b0}};
            end else begin
               count_next = count_reg - 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
            count_next = {`CSS_CNT_W{1'b0}};
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg <= ST_IDLE;
         count_reg <= {`CSS_CNT_W{1'b0}};
         op_reg <= `CSS_OP_IO_READ;
         last_reg <= 1'b0;
         wait_sync_reg <= 1'b0;
         wait_held_reg <= 1'b0;
         req_ready_out <= 1'b0;
         done_out <= 1'b0;
         rdata_out <= 16'h0000;
         read_acked_out <= 1'b0;
         dma_request_out <= 1'b0;
         card_present_out <= 1'b0;
         card_detect_level_out <= 2'h3;
         card_data_out <= 16'h0000;
         card_data_oe_out <= 1'b0;
         card_addr_out <= 26'h000_0000;
         even_byte_enable_n_out <= `CSS_PIN_IDLE;
         odd_byte_enable_n_out <= `CSS_PIN_IDLE;
         io_read_strobe_n_out <= `CSS_PIN_IDLE;
         io_write_strobe_n_out <= `CSS_PIN_IDLE;
         attr_select_n_out <= `CSS_PIN_IDLE;
         output_enable_n_out <= `CSS_PIN_IDLE;
         write_enable_n_out <= `CSS_PIN_IDLE;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         wait_sync_reg <= ~wait_n_in;
         wait_held_reg <= wait_sync_reg;
         card_present_out <= present;
         card_detect_level_out <= detect_level;
         dma_request_out <= dma_enable_in & present & dreq;
         req_ready_out <= (state_next == ST_IDLE) && (state_reg == ST_IDLE);
         done_out <= 1'b0;
         if (state_reg == ST_IDLE && state_next == ST_SETUP) begin
            op_reg <= req_op_in;
            last_reg <= req_last_in;
            card_addr_out <= req_addr_in;
            card_data_out <= req_wdata_in;
            card_data_oe_out <= ~req_op_in[0] ? 1'b0 : 1'b1;
            even_byte_enable_n_out <= lanes_n[0];
            odd_byte_enable_n_out <= lanes_n[1];
            read_acked_out <= 1'b0;
            // dma acknowledge spans the whole transfer
            attr_select_n_out <= ~req_op_in[1];
         end
         if (state_reg == ST_SETUP && state_next == ST_STROBE) begin
            io_read_strobe_n_out <= ~is_read;
            io_write_strobe_n_out <= is_read;
            output_enable_n_out <= ~(is_dma && is_read && last_reg);
            write_enable_n_out <= ~(is_dma && !is_read && last_reg);
         end
         if (state_reg == ST_STROBE) begin
            rdata_out <= card_data_in;
            // acknowledge only meaningful on host i/o reads
            if (op_reg == `CSS_OP_IO_READ && !input_acknowledge_n_in) begin
               read_acked_out <= 1'b1;
            end
         end
         if (state_reg == ST_STROBE && state_next == ST_HOLD) begin
            io_read_strobe_n_out <= `CSS_PIN_IDLE;
            io_write_strobe_n_out <= `CSS_PIN_IDLE;
            output_enable_n_out <= `CSS_PIN_IDLE;
            write_enable_n_out <= `CSS_PIN_IDLE;
         end
         if (state_reg == ST_HOLD && state_next == ST_IDLE) begin
            even_byte_enable_n_out <= `CSS_PIN_IDLE;
            odd_byte_enable_n_out <= `CSS_PIN_IDLE;
            attr_select_n_out <= `CSS_PIN_IDLE;
            card_data_oe_out <= 1'b0;
            done_out <= 1'b1;
         end
      end
   end
endmodule // css_socket

// File: sim/css_card_model.sv
// behavioural inserted card seen from the socket pins
`timescale 1ns/1ns
module css_card_model (
   input wire clk_in,
   input wire inserted_in,
   input wire ack_en_in,
   input wire [1:0] dreq_in,
   input wire [3:0] wait_len_in,
   input wire [15:0] rword_in,
   input wire io_read_strobe_n_in,
   input wire io_write_strobe_n_in,
   input wire [15:0] bus_in,
   output wire [1:0] card_detect_n_out,
   output wire battery_detect_two_n_out,
   output wire input_acknowledge_n_out,
   output wire wait_n_out,
   output wire [15:0] data_out,
   output reg [15:0] captured_out
);
reg [3:0] wait_cnt_reg = 4'h0;
wire idle = io_read_strobe_n_in & io_write_strobe_n_in;
assign card_detect_n_out = inserted_in ? 2'h0 : 2'h3;
assign battery_detect_two_n_out = ~dreq_in[0];
assign input_acknowledge_n_out = ~(dreq_in[1] | (ack_en_in & ~io_read_strobe_n_in));
assign wait_n_out = idle | (wait_cnt_reg == 4'h0);
// inverse outside the strobe so a late sample is caught
assign data_out = io_read_strobe_n_in ? ~rword_in : rword_in;
always @(posedge clk_in) begin
   if (idle) wait_cnt_reg <= wait_len_in;
   else if (wait_cnt_reg != 4'h0) wait_cnt_reg <= wait_cnt_reg - 4'h1;
end
always @(posedge io_write_strobe_n_in) begin
   captured_out <= bus_in;
end
endmodule // css_card_model

// File: sim/css_socket_properties.sv
// assertions on the socket strobe sequencer pins
`timescale 1ns/1ns
module css_socket_properties (
   input wire clk_in,
   input wire reset_in,
   input wire wait_n_in,
   input wire card_detect_one_n_in,
   input wire card_detect_two_n_in,
   input wire card_present_out,
   input wire [1:0] card_detect_level_out,
   input wire card_data_oe_out,
   input wire even_byte_enable_n_out,
   input wire odd_byte_enable_n_out,
   input wire io_read_strobe_n_out,
   input wire io_write_strobe_n_out,
   input wire attr_select_n_out,
   input wire output_enable_n_out,
   input wire write_enable_n_out
);
default clocking cb @(posedge clk_in); endclocking
default disable iff (reset_in);
wire strobe_n = io_read_strobe_n_out & io_write_strobe_n_out;
wire [1:0] cd_n = {card_detect_two_n_in, card_detect_one_n_in};
a_present_both_low: assert property (card_present_out == (card_detect_level_out == 2'h0))
   else $error("presence flag wrong");
// two sampled edges needed so reset values do not leak in
a_level_two_late: assert property (!$past(reset_in) && !$past(reset_in, 2) |->
   card_detect_level_out == $past(cd_n, 2)) else $error("detect level wrong");
a_lane_enabled: assert property (!strobe_n |-> !(even_byte_enable_n_out & odd_byte_enable_n_out))
   else $error("strobe without lane");
a_write_drives: assert property (!io_write_strobe_n_out |-> card_data_oe_out)
   else $error("write strobe undriven");
a_ack_leads: assert property ($fell(attr_select_n_out) |-> strobe_n ##3 !strobe_n)
   else $error("dma ack setup wrong");
a_tc_read: assert property (!output_enable_n_out |-> !io_read_strobe_n_out && !attr_select_n_out)
   else $error("read count misplaced");
a_tc_write: assert property (!write_enable_n_out |-> !io_write_strobe_n_out && !attr_select_n_out)
   else $error("write count misplaced");
a_wait_holds: assert property ((!wait_n_in) [*4] |=> !$rose(strobe_n))
   else $error("strobe ended in wait");
a_read_span: assert property ($fell(io_read_strobe_n_out) |-> (!io_read_strobe_n_out) [*8])
   else $error("read strobe short");
endmodule // css_socket_properties
bind css_socket css_socket_properties u_props (.*);

// File: sim/css_socket_tb_top.sv
// self-checking bench for the socket strobe sequencer
`timescale 1ns/1ns
`define CSS_CHECK(got, exp) begin n_checks = n_checks + 1; if ((got) !== (exp)) begin \
   err_total = err_total + 1; $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module css_socket_tb_top;
// row: op, bytes, last, expected {ack, read count, write count}
localparam [47:0] ROWS = 48'h3767_b3b9_d3fa;
localparam [15:0] DCASE = 16'h3da4;
reg clk_in = 1'b0, reset_in = 1'b1, req_valid_in = 1'b0, req_last_in = 1'b0, inserted = 1'b1;
reg dma_enable_in = 1'b0, dma_req_select_in = 1'b0, ack_en = 1'b1;
reg [1:0] req_op_in = 2'h0, req_bytes_in = 2'h0, dreq = 2'h0;
reg [25:0] req_addr_in = 26'h0;
reg [15:0] req_wdata_in = 16'h0, rword = 16'h0;
reg [3:0] wait_len = 4'h0;
wire done_out, read_acked_out, dma_request_out, card_present_out, card_data_oe_out, req_ready_out;
wire card_detect_one_n_in, card_detect_two_n_in, battery_detect_two_n_in;
wire input_acknowledge_n_in, wait_n_in, even_byte_enable_n_out, odd_byte_enable_n_out;
wire io_read_strobe_n_out, io_write_strobe_n_out, attr_select_n_out;
wire output_enable_n_out, write_enable_n_out;
wire [1:0] card_detect_level_out;
wire [15:0] rdata_out, card_data_out, card_word, captured;
wire [25:0] card_addr_out;
wire [15:0] card_data_in = card_data_oe_out ? card_data_out : card_word;
wire strobe_n = io_read_strobe_n_out & io_write_strobe_n_out;
integer err_total = 0, n_checks = 0, i, k, strobe_len;
css_socket u_dut (.*);
css_card_model u_card (.clk_in(clk_in), .inserted_in(inserted), .ack_en_in(ack_en),
   .dreq_in(dreq), .wait_len_in(wait_len), .rword_in(rword),
   .io_read_strobe_n_in(io_read_strobe_n_out), .io_write_strobe_n_in(io_write_strobe_n_out),
   .bus_in(card_data_in), .card_detect_n_out({card_detect_two_n_in, card_detect_one_n_in}),
   .battery_detect_two_n_out(battery_detect_two_n_in),
   .input_acknowledge_n_out(input_acknowledge_n_in), .wait_n_out(wait_n_in),
   .data_out(card_word), .captured_out(captured));
always #10 clk_in = ~clk_in;
task complete_run;
   begin
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   end
endtask
task wait_strobe(input lvl);
   begin
      k = 0;
      while (strobe_n !== lvl && k < 40) begin
         @(negedge clk_in);
         k = k + 1;
      end
      if (strobe_n !== lvl) begin
         err_total = err_total + 1;
         complete_run;
      end
   end
endtask
task run_op(input [7:0] row);
   begin
      @(negedge clk_in);
      `CSS_CHECK(req_ready_out, 1'b1)
      {req_op_in, req_bytes_in, req_last_in} = row[7:3];
      req_valid_in = 1'b1;
      wait_strobe(1'b0);
      req_valid_in = 1'b0;
      `CSS_CHECK(req_ready_out, 1'b0)
      `CSS_CHECK({attr_select_n_out, output_enable_n_out, write_enable_n_out}, row[2:0])
      `CSS_CHECK({odd_byte_enable_n_out, even_byte_enable_n_out}, ~row[5:4])
      `CSS_CHECK(card_addr_out, req_addr_in)
      wait_strobe(1'b1);
      strobe_len = k;
      for (k = 0; k < 8 && done_out !== 1'b1; k = k + 1) @(negedge clk_in);
      `CSS_CHECK(done_out, 1'b1)
      if (done_out !== 1'b1) complete_run;
   end
endtask
task refused(input [1:0] op);
   begin
      req_op_in = op;
      req_valid_in = 1'b1;
      repeat (20) @(negedge clk_in);
      `CSS_CHECK({strobe_n, done_out}, 2'h2)
      req_valid_in = 1'b0;
   end
endtask
initial begin
   repeat (10) @(negedge clk_in);
   reset_in = 1'b0;
   dma_enable_in = 1'b1;
   repeat (3) @(negedge clk_in);
   `CSS_CHECK({card_present_out, card_detect_level_out}, 3'h4)
   for (i = 0; i < 6; i = i + 1) begin
      req_addr_in = 26'h3ff_ffff ^ i[25:0];
      req_wdata_in = 16'ha5c3 ^ i[15:0];
      rword = 16'h5a3c ^ i[15:0];
      run_op(ROWS[47 - 8 * i -: 8]);
      `CSS_CHECK(strobe_len, 8)
      if (ROWS[46 - 8 * i]) `CSS_CHECK(captured, req_wdata_in)
      else `CSS_CHECK(rdata_out, rword)
      if (i == 0) `CSS_CHECK(read_acked_out, 1'b1)
   end
   dma_enable_in = 1'b0;
   refused(2'h2);
   dma_enable_in = 1'b1;
   inserted = 1'b0;
   repeat (3) @(negedge clk_in);
   `CSS_CHECK({card_present_out, card_detect_level_out}, 3'h3)
   refused(2'h0);
   inserted = 1'b1;
   for (i = 0; i < 4; i = i + 1) begin
      {dma_req_select_in, dreq} = DCASE[15 - 4 * i -: 3];
      repeat (4) @(negedge clk_in);
      `CSS_CHECK(dma_request_out, DCASE[12 - 4 * i])
   end
   dreq = 2'h0;
   ack_en = 1'b0;
   wait_len = 4'hc;
   run_op(8'h37);
   `CSS_CHECK(strobe_len > 12 && strobe_len < 17, 1'b1)
   `CSS_CHECK(read_acked_out, 1'b0)
   @(negedge clk_in);
   {req_op_in, req_valid_in} = 3'h5;
   wait_strobe(1'b0);
   reset_in = 1'b1;
   req_valid_in = 1'b0;
   @(negedge clk_in);
   `CSS_CHECK({strobe_n, attr_select_n_out, even_byte_enable_n_out}, 3'h7)
   reset_in = 1'b0;
   req_wdata_in = 16'h0f1e;
   repeat (3) @(negedge clk_in);
   run_op(8'h67);
   `CSS_CHECK(captured, 16'h0f1e)
   complete_run;
end
endmodule // css_socket_tb_top
